// file: bit_timer.sv
// Purpose: Restartable bit period counter with end and middle strobes
// Assumes: en is a same-domain pulse or held high
// Notes:   Period may change on the fly; counter wraps at or beyond it

`timescale 1ns/1ps

module bit_timer #(
	parameter int W = 5
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         restart,
	input  wire logic         en,
	input  wire logic [W-1:0] period,
	output logic              tick,
	output logic              mid
);

	// ==========================================================
	// Counter
	logic [W-1:0] cnt_q;
	wire          last = (cnt_q >= period - W'(1));

	if (W < 3) begin : g_bad_w
		$error("bit_timer width too small");
	end

	always_ff @(posedge ref_clk) begin
		if (rst || restart)
			cnt_q <= '0;
		else if (en)
			cnt_q <= last ? '0 : cnt_q + W'(1);
	end

	assign tick = en & last;
	assign mid  = en & (cnt_q == (period >> 1) - W'(1));

endmodule : bit_timer

// file: serial_ctrl.sv
// Purpose: Register control, status and framing of the serial interface
// Assumes: Classic Wishbone slave, 8-bit registers in data lane 0
// Notes:   One async bit lasts one source period, a sync bit two; async rx samples mid-bit
//
// Functional notes
// (RULE_01) Pin enable routes four pins to serial
// (RULE_02) Two-bit mode field selects async or sync
// (RULE_03) Two-bit field picks serial clock source
// (RULE_04) Slave mode uses external clock, ignores source
// (RULE_05) Parity enable adds and checks parity bit
// (RULE_06) Parity applies only in asynchronous modes
// (RULE_07) Polarity bit: one odd, zero even
// (RULE_08) Error flags set on error, write-one clears
// (RULE_09) Transmit enable bit gates transmission
// (RULE_10) Software disables both directions before reconfiguring
// (RULE_11) Transmit trigger starts; reads one while sending
// (RULE_12) Receive enable bit gates reception
// (RULE_13) Receive trigger starts sync, frees async buffer
// (RULE_14) Data register: write transmits, read received
// (RULE_15) Three interrupt enable bits, reset zero
// (RULE_16) Three factor flags, write-one clears
// (RULE_17) Two-bit priority field, zero means none
// (RULE_18) Seven-bit mode drops bit seven, which reads zero
// (RULE_19) Character before buffer freed sets overrun
// (RULE_20) Receive disable forces error flags zero
// (RULE_21) Bus writes update addressed bits next edge

`timescale 1ns/1ps

module serial_ctrl
	import serial_ctrl_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [17:2] adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        timer_tick,
	input  wire logic [3:0]  pin_in,
	output logic      [3:0]  pin_out,
	output logic      [3:0]  pin_oe,
	input  wire logic [3:0]  port_out,
	input  wire logic [3:0]  port_oe,
	output logic      [3:0]  port_in,
	output logic             irq_req,
	output logic      [1:0]  irq_level
);

	// ==========================================================
	// Bus decode
	logic        ack_q;
	logic [31:0] dat_q;
	wire  [7:0]  wd      = dat_i[7:0];
	wire         wr      = cyc_i & stb_i & we_i & ack_q & sel_i[0];
	wire         wr_prio = wr & (adr_i == IDX_PRIO);
	wire         wr_ien  = wr & (adr_i == IDX_IEN);
	wire         wr_flag = wr & (adr_i == IDX_IFLAG);
	wire         wr_mode = wr & (adr_i == IDX_MODE);
	wire         wr_ctrl = wr & (adr_i == IDX_CTRL);
	wire         wr_data = wr & (adr_i == IDX_DATA);

	// ==========================================================
	// Registers
	logic [7:0] mode_q;
	logic       tx_en_q;
	logic       rx_en_q;
	logic       rx_free_q;
	logic       ovr_q;
	logic       per_q;
	logic       fer_q;
	logic [1:0] prio_q;
	logic [2:0] ien_q;
	logic [2:0] iflag_q;
	logic [7:0] tx_data_q;
	logic [7:0] rx_buf_q;
	logic       irq_q;
	logic [1:0] lvl_q;
	logic       rdy_n_q;

	// ==========================================================
	// Mode decode
	wire [1:0] xfer   = mode_q[MODE_XFER+:2];
	wire [1:0] csrc   = mode_q[MODE_CLK+:2];
	wire       pin_en = mode_q[MODE_PIN_EN];
	wire       async  = xfer[1];
	wire       seven  = (xfer == XFER_ASYNC7);
	wire       slave  = (xfer == XFER_SLAVE);
	wire       par_on = async & mode_q[MODE_PAR_EN];    // see RULE_06
	wire       odd    = mode_q[MODE_PAR_POL];           // see RULE_07
	wire [3:0] dbits  = seven ? 4'd7 : 4'd8;
	wire [3:0] n_rx   = dbits + {3'd0, par_on};         // see RULE_05
	wire [4:0] period = (csrc == CLK_TIMER) ? PER_TIMER :
	                    (csrc == CLK_DIV4)  ? PER_DIV4  :
	                    (csrc == CLK_DIV8)  ? PER_DIV8  : PER_DIV16; // see RULE_03
	wire       src_en = (csrc == CLK_TIMER) ? timer_tick : 1'b1;

	// ==========================================================
	// Pin synchronisers
	logic sin_m_q;
	logic sin_q;
	logic sin_d1_q;
	logic sck_m_q;
	logic sck_q;
	logic sck_d1_q;

	always_ff @(posedge ref_clk) begin
		sin_m_q  <= pin_in[0];
		sin_q    <= sin_m_q;
		sin_d1_q <= sin_q;
		sck_m_q  <= pin_in[2];
		sck_q    <= sck_m_q;
		sck_d1_q <= sck_q;
	end

	// Disabled pins look idle so the engines stay quiet
	wire ser_in   = sin_q | ~pin_en;
	wire ser_in_1 = sin_d1_q | ~pin_en;
	wire sck_in   = sck_q | ~pin_en;
	wire sck_in_1 = sck_d1_q | ~pin_en;

	// ==========================================================
	// Engines
	tx_state_e  tx_st_q, tx_st_d;
	rx_state_e  rx_st_q, rx_st_d;
	logic [3:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
	logic [9:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
	logic       serial_output_pin_q, serial_output_pin_d, sclk_q;
	logic       tx_done, rx_done, per_ev, fer_ev;
	logic [7:0] rx_byte;
	logic       tick_tx, mid_rx;

	wire tx_busy  = (tx_st_q != TX_IDLE);
	wire sync_act = (tx_st_q == TX_SYNC) | (rx_st_q == RX_SYNC);
	wire tx_go    = wr_ctrl & wd[CTRL_TX_TRG] & tx_en_q & ~tx_busy
	                & (async | rx_st_q == RX_IDLE);      // see RULE_11
	wire rx_go_s  = wr_ctrl & wd[CTRL_RX_TRG] & rx_en_q & ~async
	                & (rx_st_q == RX_IDLE) & ~tx_busy;   // see RULE_13
	wire rx_go_a  = rx_en_q & async & (rx_st_q == RX_IDLE) & ser_in_1 & ~ser_in;
	wire rise_e   = slave ? (~sck_in_1 & sck_in) : (tick_tx & ~sclk_q); // see RULE_04
	wire fall_e   = slave ? (sck_in_1 & ~sck_in) : (tick_tx & sclk_q);

	bit_timer #(.W(5)) u_tx_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.restart (tx_go | rx_go_s),
		.en      (src_en),
		.period  (period),
		.tick    (tick_tx),
		.mid     ()
	);

	bit_timer #(.W(5)) u_rx_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.restart (rx_go_a),
		.en      (src_en),
		.period  (period),
		.tick    (),
		.mid     (mid_rx)
	);

	// Transmit frame: data, optional parity, stop bits fill with ones
	wire [7:0] tx_d     = seven ? {1'b0, tx_data_q[6:0]} : tx_data_q; // see RULE_18
	wire       tx_par   = ^tx_d ^ odd;
	wire [9:0] par_mask = par_on ? (10'h001 << dbits) : 10'h000;
	wire [9:0] tx_frame = ((10'h3ff << dbits) & ~(par_mask & {10{~tx_par}}))
	                      | {2'b00, tx_d};                // see RULE_05

	// Async receive word, parity and check
	wire [9:0] a_word  = rx_sh_q >> (4'd10 - n_rx);
	wire [7:0] a_byte  = seven ? {1'b0, a_word[6:0]} : a_word[7:0]; // see RULE_18
	wire       a_par   = a_word[n_rx - 4'd1];
	wire       par_err = par_on & (^a_byte ^ a_par ^ odd);       // see RULE_05

	always_comb begin
		tx_st_d  = tx_st_q;
		tx_cnt_d = tx_cnt_q;
		tx_sh_d  = tx_sh_q;
		serial_output_pin_d   = serial_output_pin_q;
		tx_done  = 1'b0;
		unique case (tx_st_q)
			TX_IDLE: begin
				serial_output_pin_d = 1'b1;
				if (tx_go && async) begin
					tx_st_d  = TX_ASYNC;
					serial_output_pin_d   = 1'b0;
					tx_sh_d  = tx_frame;
					tx_cnt_d = n_rx + 4'd1;
				end else if (tx_go) begin
					tx_st_d  = TX_SYNC;
					tx_sh_d  = {2'b11, tx_data_q};
					tx_cnt_d = SYNC_BITS;
				end
			end
			TX_ASYNC: begin
				if (tick_tx) begin
					if (tx_cnt_q == 4'd0) begin
						tx_st_d = TX_IDLE;
						tx_done = 1'b1;
					end else begin
						serial_output_pin_d   = tx_sh_q[0];
						tx_sh_d  = {1'b1, tx_sh_q[9:1]};
						tx_cnt_d = tx_cnt_q - 4'd1;
					end
				end
			end
			TX_SYNC: begin
				if (fall_e) begin
					serial_output_pin_d  = tx_sh_q[0];
					tx_sh_d = {1'b1, tx_sh_q[9:1]};
				end
				if (rise_e) begin
					tx_cnt_d = tx_cnt_q - 4'd1;
					if (tx_cnt_q == 4'd1) begin
						tx_st_d = TX_IDLE;
						tx_done = 1'b1;
					end
				end
			end
		endcase
		if (!tx_en_q) begin                                 // see RULE_09
			tx_st_d = TX_IDLE;
			serial_output_pin_d  = 1'b1;
			tx_done = 1'b0;
		end
	end

	always_comb begin
		rx_st_d  = rx_st_q;
		rx_cnt_d = rx_cnt_q;
		rx_sh_d  = rx_sh_q;
		rx_done  = 1'b0;
		per_ev   = 1'b0;
		fer_ev   = 1'b0;
		rx_byte  = a_byte;
		unique case (rx_st_q)
			RX_IDLE: begin
				if (rx_go_a) begin
					rx_st_d  = RX_ASYNC;
					rx_cnt_d = 4'd0;
				end else if (rx_go_s) begin
					rx_st_d  = RX_SYNC;
					rx_cnt_d = SYNC_BITS;
				end
			end
			RX_ASYNC: begin
				if (mid_rx) begin
					if (rx_cnt_q == 4'd0 && ser_in) begin
						rx_st_d = RX_IDLE;
					end else if (rx_cnt_q == n_rx + 4'd1) begin
						rx_st_d = RX_IDLE;
						rx_done = 1'b1;
						fer_ev  = ~ser_in;
						per_ev  = par_err;
					end else begin
						rx_cnt_d = rx_cnt_q + 4'd1;
						if (rx_cnt_q != 4'd0)
							rx_sh_d = {ser_in, rx_sh_q[9:1]};
					end
				end
			end
			RX_SYNC: begin
				rx_byte = {ser_in, rx_sh_q[9:3]};
				if (rise_e) begin
					rx_sh_d  = {ser_in, rx_sh_q[9:1]};
					rx_cnt_d = rx_cnt_q - 4'd1;
					if (rx_cnt_q == 4'd1) begin
						rx_st_d = RX_IDLE;
						rx_done = 1'b1;
					end
				end
			end
		endcase
		if (!rx_en_q) begin                                 // see RULE_12
			rx_st_d = RX_IDLE;
			rx_done = 1'b0;
			per_ev  = 1'b0;
			fer_ev  = 1'b0;
		end
	end

	wire ovr_ev = rx_done & async & ~rx_free_q;             // see RULE_19
	wire err_ev = ovr_ev | per_ev | fer_ev;

	// ==========================================================
	// State registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_st_q  <= TX_IDLE;
			rx_st_q  <= RX_IDLE;
			tx_cnt_q <= 4'h0;
			rx_cnt_q <= 4'h0;
			tx_sh_q  <= 10'h3ff;
			rx_sh_q  <= 10'h000;
			serial_output_pin_q   <= 1'b1;
		end else begin
			tx_st_q  <= tx_st_d;
			rx_st_q  <= rx_st_d;
			tx_cnt_q <= tx_cnt_d;
			rx_cnt_q <= rx_cnt_d;
			tx_sh_q  <= tx_sh_d;
			rx_sh_q  <= rx_sh_d;
			serial_output_pin_q   <= serial_output_pin_d;
		end
	end

	// Master clock idles high; slave leaves the pin undriven
	always_ff @(posedge ref_clk) begin
		if (rst)
			sclk_q <= 1'b1;
		else if (sync_act && !slave && tick_tx)
			sclk_q <= ~sclk_q;
		else if (!sync_act)
			sclk_q <= 1'b1;
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_q  <= REG_RESET;
			tx_en_q <= 1'b0;
			rx_en_q <= 1'b0;
			prio_q  <= 2'h0;
			ien_q   <= 3'h0;
		end else begin
			if (wr_mode)
				mode_q <= wd & MODE_WR_MASK;                // see RULE_02
			if (wr_ctrl) begin
				tx_en_q <= wd[CTRL_TX_EN];                  // see RULE_09
				rx_en_q <= wd[CTRL_RX_EN];                  // see RULE_12
			end
			if (wr_prio)
				prio_q <= wd[PRIO_LSB+:2];                  // see RULE_17
			if (wr_ien)
				ien_q <= wd[2:0];                           // see RULE_15
		end
	end

	// Sticky flags: a set in the same cycle as a clear wins
	always_ff @(posedge ref_clk) begin
		if (rst || !rx_en_q) begin                          // see RULE_20
			ovr_q     <= 1'b0;
			per_q     <= 1'b0;
			fer_q     <= 1'b0;
			rx_free_q <= 1'b0;
		end else begin
			ovr_q <= ovr_ev | (ovr_q & ~(wr_ctrl & wd[CTRL_OVR]));     // see RULE_08
			per_q <= per_ev | (per_q & ~(wr_ctrl & wd[CTRL_PAR_ERR]));
			fer_q <= fer_ev | (fer_q & ~(wr_ctrl & wd[CTRL_FRM_ERR]));
			if (wr_ctrl && wd[CTRL_RX_TRG] && async)
				rx_free_q <= 1'b1;                          // see RULE_13
			else if (rx_done)
				rx_free_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			iflag_q <= 3'h0;
		else
			iflag_q <= {err_ev, rx_done, tx_done}
			           | (iflag_q & ~(wr_flag ? wd[2:0] : 3'h0)); // see RULE_16
	end

	// Data holds no reset value, as the buffer is undefined after reset
	always_ff @(posedge ref_clk) begin
		if (wr_data)
			tx_data_q <= wd;                                // see RULE_14
		if (rx_done)
			rx_buf_q <= rx_byte;
	end

	// ==========================================================
	// Readback and bus answer
	wire       rx_trg_rd = rx_free_q | (rx_st_q == RX_SYNC);
	wire [7:0] ctrl_rd   = {1'b0, fer_q, per_q, ovr_q, rx_trg_rd, rx_en_q, tx_busy, tx_en_q};
	wire [7:0] rd_val    = (adr_i == IDX_PRIO)  ? {2'b00, prio_q, 4'h0} :
	                       (adr_i == IDX_IEN)   ? {5'h00, ien_q} :
	                       (adr_i == IDX_IFLAG) ? {5'h00, iflag_q} :
	                       (adr_i == IDX_MODE)  ? mode_q :
	                       (adr_i == IDX_CTRL)  ? ctrl_rd :
	                       (adr_i == IDX_DATA)  ? rx_buf_q : 8'h00;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_q   <= 1'b0;
			dat_q   <= 32'h0;
			irq_q   <= 1'b0;
			lvl_q   <= 2'h0;
			rdy_n_q <= 1'b1;
		end else begin
			ack_q   <= cyc_i & stb_i & ~ack_q;              // see RULE_21
			if (cyc_i && stb_i && !ack_q)
				dat_q <= {24'h0, rd_val};
			irq_q   <= (|(iflag_q & ien_q)) & (prio_q != 2'h0); // see RULE_17
			lvl_q   <= prio_q;
			rdy_n_q <= ~(slave & sync_act);
		end
	end

	assign ack_o     = ack_q;
	assign dat_o     = dat_q;
	assign irq_req   = irq_q;
	assign irq_level = lvl_q;
	assign port_in   = pin_in;

	// ==========================================================
	// Pin routing
	assign pin_out[0] = port_out[0];                        // see RULE_01
	assign pin_oe[0]  = pin_en ? 1'b0 : port_oe[0];
	assign pin_out[1] = pin_en ? serial_output_pin_q : port_out[1];
	assign pin_oe[1]  = pin_en ? 1'b1 : port_oe[1];
	assign pin_out[2] = pin_en ? sclk_q : port_out[2];
	assign pin_oe[2]  = pin_en ? (~async & ~slave) : port_oe[2]; // see RULE_04
	assign pin_out[3] = pin_en ? rdy_n_q : port_out[3];
	assign pin_oe[3]  = pin_en ? slave : port_oe[3];

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	pin_route_a: assert property (wr_mode && wd[0] |=> pin_oe[1] && pin_out[1] == serial_output_pin_q) // see RULE_01
		else $error("pin enable did not route output");
	mode_write_a: assert property (wr_mode |=> mode_q == $past(wd & MODE_WR_MASK)) // see RULE_21
		else $error("mode write not stored");
	tx_status_a: assert property (tx_go |=> tx_busy && ctrl_rd[1]) // see RULE_11
		else $error("transmit status not running");
	tx_disable_a: assert property (!tx_en_q |=> !tx_busy) // see RULE_09
		else $error("transmit active while disabled");
	err_clear_a: assert property (wr_ctrl && wd[CTRL_OVR] && !ovr_ev |=> !ovr_q) // see RULE_08
		else $error("overrun flag not cleared");
	err_force_a: assert property (!rx_en_q |=> !(fer_q || per_q || ovr_q)) // see RULE_20
		else $error("error flag set while receive off");
	overrun_set_a: assert property (rx_done && async && !rx_free_q |=> ovr_q && iflag_q[2]) // see RULE_19
		else $error("overrun not flagged");
	sync_parity_a: assert property (rx_done && !async |-> !per_ev) // see RULE_06
		else $error("parity checked in sync mode");
	seven_bit_a: assert property (rx_done && seven |=> !rx_buf_q[7]) // see RULE_18
		else $error("bit seven not zero");
	factor_set_a: assert property (tx_done |=> iflag_q[0] ##1 ($stable(iflag_q[0]) || $past(wr_flag))) // see RULE_16
		else $error("transmit factor not set");
	prio_none_a: assert property (prio_q == 2'h0 |=> !irq_q) // see RULE_17
		else $error("request with priority zero");

endmodule : serial_ctrl

// file: serial_ctrl_pkg.sv
// Purpose: Shared constants for the serial interface control block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Only bits owned by the serial interface are held in shared registers

package serial_ctrl_pkg;

	// ==========================================================
	// Register indices
	localparam logic [15:0] IDX_PRIO  = 16'hff20;
	localparam logic [15:0] IDX_IEN   = 16'hff23;
	localparam logic [15:0] IDX_IFLAG = 16'hff25;
	localparam logic [15:0] IDX_MODE  = 16'hff48;
	localparam logic [15:0] IDX_CTRL  = 16'hff49;
	localparam logic [15:0] IDX_DATA  = 16'hff4a;

	// ==========================================================
	// Field positions
	localparam int MODE_PIN_EN  = 0;
	localparam int MODE_XFER    = 1;
	localparam int MODE_CLK     = 3;
	localparam int MODE_PAR_POL = 5;
	localparam int MODE_PAR_EN  = 6;
	localparam int CTRL_TX_EN   = 0;
	localparam int CTRL_TX_TRG  = 1;
	localparam int CTRL_RX_EN   = 2;
	localparam int CTRL_RX_TRG  = 3;
	localparam int CTRL_OVR     = 4;
	localparam int CTRL_PAR_ERR = 5;
	localparam int CTRL_FRM_ERR = 6;
	localparam int PRIO_LSB     = 4;

	// ==========================================================
	// Reset values and encodings
	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam logic [7:0] MODE_WR_MASK  = 8'h7f;
	localparam logic [1:0] XFER_ASYNC8   = 2'h3;
	localparam logic [1:0] XFER_ASYNC7   = 2'h2;
	localparam logic [1:0] XFER_SLAVE    = 2'h1;
	localparam logic [1:0] XFER_MASTER   = 2'h0;
	localparam logic [1:0] CLK_TIMER     = 2'h3;
	localparam logic [1:0] CLK_DIV4      = 2'h2;
	localparam logic [1:0] CLK_DIV8      = 2'h1;
	localparam logic [1:0] CLK_DIV16     = 2'h0;

	// ==========================================================
	// Cycle counts per source period: one async bit, half a sync bit
	localparam logic [4:0] PER_DIV4   = 5'h04;
	localparam logic [4:0] PER_DIV8   = 5'h08;
	localparam logic [4:0] PER_DIV16  = 5'h10;
	localparam logic [4:0] PER_TIMER  = 5'h02;
	localparam logic [3:0] SYNC_BITS  = 4'h8;

	typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_e;
	typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} rx_state_e;

endpackage : serial_ctrl_pkg

// file: serial_ctrl_tb.sv
// Purpose: Self-checking bench for the serial control block
// Assumes: Clock source divide-by-4, so one async bit is four clocks and one sync bit eight
// Notes:   Sync mode is exercised as master transmit only

`timescale 1ns/1ps

module serial_ctrl_tb;
	import serial_ctrl_pkg::*;

	// ==========================================================
	// Signals
	logic        ref_clk    = 1'b0;
	logic        rst        = 1'b1;
	logic        cyc_i      = 1'b0;
	logic        stb_i      = 1'b0;
	logic        we_i       = 1'b0;
	logic [17:2] adr_i      = 16'h0000;
	logic [31:0] dat_i      = 32'h00000000;
	logic [3:0]  sel_i      = 4'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        timer_tick = 1'b0;
	wire  [3:0]  pin_in;
	logic [2:0]  pin_hi     = 3'h0;
	logic        peer_line;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe;
	logic [3:0]  port_out   = 4'h0;
	logic [3:0]  port_oe    = 4'h0;
	logic [3:0]  port_in;
	logic        irq_req;
	logic [1:0]  irq_level;
	logic [7:0]  rd;
	logic [9:0]  frame;
	int          bad_count;
	int          total_checks;
	int          i;

	always #50 ref_clk = ~ref_clk;
	assign pin_in = {pin_hi, peer_line};

	serial_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
		.ack_o(ack_o), .timer_tick(timer_tick), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .port_out(port_out), .port_oe(port_oe), .port_in(port_in),
		.irq_req(irq_req), .irq_level(irq_level));

	serial_peer #(.BIT_CYC(4)) u_peer (.ref_clk(ref_clk), .line_o(peer_line),
		.line_i(pin_out[1]));

	// ==========================================================
	// Bus and compare tasks
	task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d,
		input logic [3:0] s, output logic [7:0] q);
		@(posedge ref_clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		sel_i <= s;
		// No local limit: a missing ack is caught by the watchdog
		do begin
			@(posedge ref_clk);
		end while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(a, 1'b1, d, 4'h1, q);
	endtask : wr

	task automatic check_reg(input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus(a, 1'b0, 8'h00, 4'h1, q);
		total_checks++;
		if (q !== exp) begin
			bad_count++;
			$display("mismatch %0t reg %h got %h want %h", $time, a, q, exp);
		end
	endtask : check_reg

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %0t pin got %h want %h", $time, got, exp);
		end
	endtask : check_val

	task automatic complete_run;
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// ==========================================================
	// Watchdog, far above the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		complete_run();
	end

	// ==========================================================
	// Tests
	initial begin
		bad_count = 0;
		total_checks = 0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		check_reg(IDX_PRIO, REG_RESET);
		check_reg(IDX_IEN, REG_RESET);
		check_reg(IDX_IFLAG, REG_RESET);
		check_reg(IDX_MODE, REG_RESET);
		check_reg(IDX_CTRL, REG_RESET);
		check_reg(16'hff30, 8'h00);
		port_out <= 4'ha;
		port_oe  <= 4'h5;
		pin_hi   <= 3'h5;
		repeat (2) @(posedge ref_clk);
		check_val(pin_out, 4'ha);
		check_val(pin_oe, 4'h5);
		check_val(port_in, 4'hb);
		for (i = 0; i < 4; i++) begin
			wr(IDX_MODE, 8'(i * 10));
			check_reg(IDX_MODE, 8'(i * 10));
		end
		wr(IDX_MODE, 8'hff);
		check_reg(IDX_MODE, 8'h7f);
		wr(IDX_PRIO, 8'hff);
		check_reg(IDX_PRIO, 8'h30);
		bus(IDX_PRIO, 1'b1, 8'h00, 4'h0, rd);
		check_reg(IDX_PRIO, 8'h30);
		wr(IDX_IEN, 8'hff);
		check_reg(IDX_IEN, 8'h07);
		wr(IDX_IEN, 8'h01);
		// Async 8-bit transmit, odd parity; config changed with both enables low
		wr(IDX_MODE, 8'h77);
		@(posedge ref_clk);
		check_val({pin_oe[1:0], pin_out[1]}, 3'b101);
		check_val({irq_req, irq_level}, 3'b011);
		wr(IDX_DATA, 8'ha5);
		wr(IDX_CTRL, 8'h02);
		check_reg(IDX_CTRL, 8'h00);
		wr(IDX_CTRL, 8'h01);
		fork
			begin
				wr(IDX_CTRL, 8'h03);
				check_reg(IDX_CTRL, 8'h03);
			end
			u_peer.capture(10, frame);
		join
		check_val(frame, {2'b11, 8'ha5});
		repeat (10) @(posedge ref_clk);
		check_reg(IDX_CTRL, 8'h01);
		check_reg(IDX_IFLAG, 8'h01);
		check_val({irq_req, irq_level}, 3'b111);
		wr(IDX_IFLAG, 8'h01);
		check_reg(IDX_IFLAG, 8'h00);
		// Async 8-bit receive, even parity, then each error kind
		wr(IDX_CTRL, 8'h00);
		wr(IDX_MODE, 8'h57);
		// Trigger only counts once receive is already enabled
		wr(IDX_CTRL, 8'h04);
		wr(IDX_CTRL, 8'h0c);
		check_reg(IDX_CTRL, 8'h0c);
		u_peer.send(8'h3c, 8, 1'b1, 1'b0, 1'b0, 1'b1);
		repeat (6) @(posedge ref_clk);
		check_reg(IDX_IFLAG, 8'h02);
		check_reg(IDX_DATA, 8'h3c);
		check_reg(IDX_CTRL, 8'h04);
		u_peer.send(8'h3c, 8, 1'b1, 1'b0, 1'b0, 1'b1);
		repeat (6) @(posedge ref_clk);
		check_reg(IDX_CTRL, 8'h14);
		check_reg(IDX_IFLAG, 8'h06);
		wr(IDX_CTRL, 8'h1c);
		check_reg(IDX_CTRL, 8'h0c);
		u_peer.send(8'h3c, 8, 1'b1, 1'b0, 1'b1, 1'b1);
		repeat (6) @(posedge ref_clk);
		check_reg(IDX_CTRL, 8'h24);
		wr(IDX_CTRL, 8'h2c);
		u_peer.send(8'h3c, 8, 1'b1, 1'b0, 1'b0, 1'b0);
		repeat (6) @(posedge ref_clk);
		check_reg(IDX_CTRL, 8'h44);
		wr(IDX_CTRL, 8'h04);
		check_reg(IDX_CTRL, 8'h44);
		wr(IDX_CTRL, 8'h00);
		check_reg(IDX_CTRL, 8'h00);
		// Async 7-bit receive with parity: top bit reads zero
		wr(IDX_MODE, 8'h55);
		wr(IDX_CTRL, 8'h04);
		wr(IDX_CTRL, 8'h0c);
		u_peer.send(8'h7f, 7, 1'b1, 1'b0, 1'b0, 1'b1);
		repeat (6) @(posedge ref_clk);
		check_reg(IDX_DATA, 8'h7f);
		check_reg(IDX_CTRL, 8'h04);
		// Sync master transmit with parity set: eight bits, no parity bit
		wr(IDX_CTRL, 8'h00);
		wr(IDX_MODE, 8'h51);
		wr(IDX_DATA, 8'h5a);
		wr(IDX_CTRL, 8'h01);
		check_val({pin_oe[3:2], pin_out[3:2]}, 4'h7);
		fork
			wr(IDX_CTRL, 8'h03);
			for (i = 0; i < 8; i++) begin
				@(posedge pin_out[2]);
				frame[i] = pin_out[1];
			end
		join
		check_val(frame[7:0], 8'h5a);
		check_reg(IDX_CTRL, 8'h01);
		complete_run();
	end
endmodule : serial_ctrl_tb

// file: serial_peer.sv
// Purpose: Remote asynchronous peer for the serial control block
// Assumes: One bit lasts BIT_CYC system clocks
// Notes:   Line rests at mark level between frames, as an idle async line does

`timescale 1ns/1ps

module serial_peer #(
	parameter int BIT_CYC = 4
) (
	input  wire logic ref_clk,
	output logic      line_o,
	input  wire logic line_i
);
	// ==========================================================
	// Frame sender
	initial line_o = 1'b1;

	task automatic send(input logic [7:0] d, input int nb, input logic par_en,
		input logic odd, input logic bad_par, input logic stop);
		logic p;
		int   i;
		p = ^(d & ((8'h01 << nb) - 8'h01)) ^ odd ^ bad_par;
		@(posedge ref_clk) line_o <= 1'b0;
		repeat (BIT_CYC - 1) @(posedge ref_clk);
		for (i = 0; i < nb + 32'(par_en) + 1; i++) begin
			@(posedge ref_clk) line_o <= (i < nb) ? d[i] : (i == nb && par_en) ? p : stop;
			repeat (BIT_CYC - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk) line_o <= 1'b1;
	endtask : send

	// ==========================================================
	// Frame capture, sampled mid-bit
	task automatic capture(input int nb, output logic [9:0] v);
		int i;
		int n;
		v = '0;
		n = 0;
		while (line_i !== 1'b0 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (BIT_CYC / 2) @(posedge ref_clk);
		for (i = 0; i < nb; i++) begin
			repeat (BIT_CYC) @(posedge ref_clk);
			v[i] = line_i;
		end
	endtask : capture
endmodule : serial_peer
